// >>> design/i2cs_pkg.sv
// Types shared by the register port files
package i2cs_pkg;

  typedef logic [7:0] i2cs_byte_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_MACK = 3'b101,
    ST_SKIP = 3'b110
  } i2cs_state_t;

endpackage

// >>> design/i2cs_port.sv
// Serial slave port that reads and writes the device's internal registers
`timescale 1ns/1ps
`include "i2cs_regs.svh"

module i2cs_port
#(
  parameter int CLK_HZ = `I2CS_CLK_HZ
)
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_sio_d,
  output logic o_sio_d,
  output logic o_sio_d_oe_n,
  input wire logic i_sio_c,
  output logic o_sio_c,
  output logic o_sio_c_oe_n,
  input wire i2cs_pkg::i2cs_byte_t i_reg_rdata,
  output i2cs_pkg::i2cs_byte_t o_reg_ptr,
  output i2cs_pkg::i2cs_byte_t o_reg_waddr,
  output i2cs_pkg::i2cs_byte_t o_reg_wdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic o_busy,
  output logic o_swapped
);
  import i2cs_pkg::*;

  // ----------------------------------------------------------------
  // Rate check
  // ----------------------------------------------------------------
  // The pin filter costs four cycles; slower clocks would blur bit edges
  if (CLK_HZ / `I2CS_SCL_FAST_HZ < `I2CS_BIT_CYC_MIN)
  begin : g_rate_chk
    $error("i2cs_port: system clock too slow for the fast bus rate");
  end

  // ----------------------------------------------------------------
  // Pin filters and line mapping
  // ----------------------------------------------------------------
  logic d_lvl;
  logic c_lvl;
  logic d_p_r;
  logic c_p_r;
  logic sda;
  logic scl;
  logic sda_p;
  logic scl_p;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic start_direct;
  logic start_cross;

  i2cs_sync u_sync_d
  (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_sio_d),
    .o_level(d_lvl)
  );

  i2cs_sync u_sync_c
  (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_sio_c),
    .o_level(c_lvl)
  );

  // ----------------------------------------------------------------
  // Port state
  // ----------------------------------------------------------------
  i2cs_state_t state_r;
  i2cs_state_t state_nxt;
  logic swap_r;
  logic swap_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  i2cs_byte_t rx_r;
  i2cs_byte_t rx_nxt;
  i2cs_byte_t tx_r;
  i2cs_byte_t tx_nxt;
  i2cs_byte_t ptr_r;
  i2cs_byte_t ptr_nxt;
  i2cs_byte_t waddr_r;
  i2cs_byte_t waddr_nxt;
  i2cs_byte_t wdata_r;
  i2cs_byte_t wdata_nxt;
  logic rw_r;
  logic rw_nxt;
  logic first_r;
  logic first_nxt;
  logic drv_r;
  logic drv_nxt;
  logic wr_r;
  logic wr_nxt;
  logic rd_r;
  logic rd_nxt;
  logic d_oe_n_r;
  logic c_oe_n_r;
  logic pin_lvl_r;
  logic busy_r;
  logic [6:0] own_addr;

  always_comb
  begin
    sda = swap_r ? c_lvl : d_lvl;
    scl = swap_r ? d_lvl : c_lvl;
    sda_p = swap_r ? c_p_r : d_p_r;
    scl_p = swap_r ? d_p_r : c_p_r;
    scl_rise = scl & ~scl_p;
    scl_fall = ~scl & scl_p;
    start_det = sda_p & ~sda & scl & scl_p;
    stop_det = ~sda_p & sda & scl & scl_p;
    // From idle the line that falls first under a high partner is data
    start_direct = d_p_r & ~d_lvl & c_lvl & c_p_r;
    start_cross = c_p_r & ~c_lvl & d_lvl & d_p_r;
    own_addr = swap_r ? `I2CS_ADDR_SWAPPED : `I2CS_ADDR_DIRECT;
  end

  always_comb
  begin
    state_nxt = state_r;
    swap_nxt = swap_r;
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    rw_nxt = rw_r;
    first_nxt = first_r;
    drv_nxt = drv_r;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    if (state_r == ST_IDLE)
    begin
      if (start_direct || start_cross)
      begin
        swap_nxt = start_cross;
        state_nxt = ST_ADDR;
        cnt_nxt = '0;
      end
    end
    else if (start_det)
    begin
      state_nxt = ST_ADDR;
      cnt_nxt = '0;
      drv_nxt = 1'b0;
    end
    else if (stop_det)
    begin
      state_nxt = ST_IDLE;
      drv_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            rx_nxt = {rx_r[6:0], sda};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == `I2CS_BYTE_BITS)
          begin
            cnt_nxt = '0;
            drv_nxt = 1'b1;
            state_nxt = ST_ACK;
            if (state_r == ST_ADDR)
            begin
              rw_nxt = rx_r[0];
              first_nxt = 1'b1;
              if (rx_r[7:1] != own_addr)
              begin
                drv_nxt = 1'b0;
                state_nxt = ST_SKIP;
              end
            end
            else if (first_r)
            begin
              ptr_nxt = rx_r;
              first_nxt = 1'b0;
            end
            else
            begin
              waddr_nxt = ptr_r;
              wdata_nxt = rx_r;
              wr_nxt = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        ST_ACK:
        begin
          // Line held low across the whole high phase; on the fall a write releases it, a read drives bit 7
          if (scl_fall)
          begin
            if (rw_r == `I2CS_DIR_READ)
            begin
              drv_nxt = ~i_reg_rdata[7];
              tx_nxt = {i_reg_rdata[6:0], 1'b0};
              rd_nxt = 1'b1;
              state_nxt = ST_TX;
            end
            else
            begin
              drv_nxt = 1'b0;
              state_nxt = ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (scl_rise)
          begin
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt_r == `I2CS_BYTE_BITS)
            begin
              cnt_nxt = '0;
              drv_nxt = 1'b0;
              ptr_nxt = ptr_r + 8'h01;
              state_nxt = ST_MACK;
            end
            else
            begin
              drv_nxt = ~tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise && sda)
          begin
            state_nxt = ST_SKIP;
          end
          else if (scl_fall)
          begin
            drv_nxt = ~i_reg_rdata[7];
            tx_nxt = {i_reg_rdata[6:0], 1'b0};
            rd_nxt = 1'b1;
            state_nxt = ST_TX;
          end
        end
        ST_SKIP:
        begin
          drv_nxt = 1'b0;
        end
        default:
        begin
          state_nxt = ST_IDLE;
          drv_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      state_r <= ST_IDLE;
      swap_r <= 1'b0;
      cnt_r <= '0;
      rx_r <= '0;
      tx_r <= '0;
      ptr_r <= `I2CS_PTR_RESET;
      waddr_r <= '0;
      wdata_r <= '0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      drv_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      d_p_r <= 1'b1;
      c_p_r <= 1'b1;
      d_oe_n_r <= 1'b1;
      c_oe_n_r <= 1'b1;
      pin_lvl_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      swap_r <= swap_nxt;
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      drv_r <= drv_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      d_p_r <= d_lvl;
      c_p_r <= c_lvl;
      // Only the pin that carries data is ever pulled low
      d_oe_n_r <= ~(drv_nxt & ~swap_nxt);
      c_oe_n_r <= ~(drv_nxt & swap_nxt);
      pin_lvl_r <= 1'b0;
      busy_r <= (state_nxt != ST_IDLE);
    end
  end

  assign o_sio_d = pin_lvl_r;
  assign o_sio_c = pin_lvl_r;
  assign o_sio_d_oe_n = d_oe_n_r;
  assign o_sio_c_oe_n = c_oe_n_r;
  assign o_reg_ptr = ptr_r;
  assign o_reg_waddr = waddr_r;
  assign o_reg_wdata = wdata_r;
  assign o_reg_wr = wr_r;
  assign o_reg_rd = rd_r;
  assign o_busy = busy_r;
  assign o_swapped = swap_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_idle_released: assert property (state_r == ST_IDLE |-> !drv_r)
    else $error("line driven while idle");
  a_start_addr: assert property (state_r != ST_IDLE && start_det
    |=> state_r == ST_ADDR && cnt_r == 4'h0 && !drv_r)
    else $error("start did not restart address phase");
  a_stop_idle: assert property (state_r != ST_IDLE && !start_det && stop_det
    |=> state_r == ST_IDLE)
    else $error("stop did not end transfer");
  a_data_stable: assert property ($changed(drv_r) && !$past(start_det)
    && !$past(stop_det) |-> !scl_p)
    else $error("data changed while clock high");
  a_addr_ack: assert property (state_r == ST_ADDR && scl_fall && cnt_r == 4'h8
    && rx_r[7:1] == own_addr |=> state_r == ST_ACK && drv_r)
    else $error("matching address not acknowledged");
  a_ack_hold: assert property (state_r == ST_ACK && scl_rise
    |-> drv_nxt ##1 drv_r [*3])
    else $error("acknowledge not held low");
  a_ptr_load: assert property (state_r == ST_RX && scl_fall && cnt_r == 4'h8
    && first_r && !start_det && !stop_det |=> ptr_r == $past(rx_r))
    else $error("pointer not loaded from first byte");
  a_write_incr: assert property (wr_r |-> ptr_r == waddr_r + 8'h01
    && !$past(wr_r))
    else $error("write not followed by pointer increment");
  a_nack_release: assert property (state_r == ST_MACK && scl_rise && sda
    && !start_det && !stop_det |=> state_r == ST_SKIP ##1 !drv_r)
    else $error("not-acknowledge did not release line");
  a_miss_ignore: assert property (state_r == ST_SKIP |-> !drv_r && !wr_r)
    else $error("ignored transfer touched the bus");
  a_clk_free: assert property (!o_sio_c_oe_n |-> swap_r && state_r != ST_IDLE)
    else $error("clock pin driven");

endmodule

// >>> design/i2cs_regs.svh
// Constants of the register port: slave addresses, bit framing and timing
`ifndef I2CS_REGS_SVH
`define I2CS_REGS_SVH

// ----------------------------------------------------------------
// Slave addresses
// ----------------------------------------------------------------
`define I2CS_ADDR_DIRECT 7'h30
`define I2CS_ADDR_SWAPPED 7'h31
`define I2CS_DIR_READ 1'b1

// ----------------------------------------------------------------
// Framing
// ----------------------------------------------------------------
`define I2CS_BYTE_BITS 4'h8
`define I2CS_PTR_RESET 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define I2CS_CLK_HZ 100000000
`define I2CS_SCL_STD_HZ 100000
`define I2CS_SCL_FAST_HZ 400000
// Cycles of the system clock per bus bit at the fastest bus rate
`define I2CS_BIT_CYC (`I2CS_CLK_HZ / `I2CS_SCL_FAST_HZ)
// Least cycles per bit that leave room for the 3-stage pin filter
`define I2CS_BIT_CYC_MIN 16

`endif

// >>> design/i2cs_sync.sv
// Three-stage pin filter: a change counts once stages two and three agree
`timescale 1ns/1ps

module i2cs_sync
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  output logic o_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  logic lvl_nxt;

  // Idle bus level is high, so every stage resets high
  always_comb
  begin
    lvl_nxt = lvl_r;
    if (s2_r == s3_r)
    begin
      lvl_nxt = s3_r;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      lvl_r <= 1'b1;
    end
    else
    begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign o_level = lvl_r;

endmodule

// >>> dv/i2cs_bus_master.sv
// Bus master model: clock, start, stop and bytes on an open-drain pair
`timescale 1ns/1ps

module i2cs_bus_master
(
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_sda_low,
  output logic o_scl_low
);
  // Quarter bit in system cycles; 63 keeps the bus just under 400 kHz
  int qtr = 63;

  initial
  begin
    o_sda_low = 1'b0; // Both lines released high while idle
    o_scl_low = 1'b0;
  end

  task automatic wq();
    repeat (qtr) @(posedge i_ref_clk);
    #1;
  endtask

  // ------------------------------------------------------------
  // Conditions
  // ------------------------------------------------------------
  // Works from idle and as a repeated start
  task automatic start();
    o_sda_low = 1'b0;
    wq();
    o_scl_low = 1'b0;
    wq();
    o_sda_low = 1'b1;
    wq();
    o_scl_low = 1'b1;
    wq();
  endtask

  task automatic stop();
    o_sda_low = 1'b1;
    wq();
    o_scl_low = 1'b0;
    wq();
    o_sda_low = 1'b0;
    wq();
  endtask

  // ------------------------------------------------------------
  // Bits and bytes
  // ------------------------------------------------------------
  // Data set while clock low, held over the high phase
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = ~b;
    wq();
    o_scl_low = 1'b0;
    wq();
    r = i_sda;
    wq();
    o_scl_low = 1'b1;
    wq();
  endtask

  // Eight bits MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ak_in,
                      output logic [7:0] rx, output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ak_in, ak);
  endtask
endmodule

// >>> dv/i2cs_port_tb.sv
// Testbench of the register port with a bus master model and register array
`timescale 1ns/1ps
`include "i2cs_regs.svh"

module i2cs_port_tb;
  import i2cs_pkg::*;

  logic i_ref_clk;
  logic i_sys_rst;
  logic swap;
  logic sda;
  logic scl;
  logic m_sda_low;
  logic m_scl_low;
  logic d_oe_n;
  logic c_oe_n;
  logic wr;
  logic rd;
  logic d_out;
  logic c_out;
  logic busy;
  logic swapped;
  logic ak;
  i2cs_byte_t ptr;
  i2cs_byte_t waddr;
  i2cs_byte_t wdata;
  i2cs_byte_t rx;
  i2cs_byte_t regs [256];
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int rd_cnt = 0;
  int rd_base;

  // Pull-ups on both lines; swapped wiring crosses the pins
  assign sda = ~m_sda_low & (swap ? c_oe_n : d_oe_n);
  assign scl = ~m_scl_low & (swap ? d_oe_n : c_oe_n);

  i2cs_port i_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_sio_d(swap ? scl : sda), .o_sio_d(d_out), .o_sio_d_oe_n(d_oe_n),
    .i_sio_c(swap ? sda : scl), .o_sio_c(c_out), .o_sio_c_oe_n(c_oe_n),
    .i_reg_rdata(regs[ptr]), .o_reg_ptr(ptr), .o_reg_waddr(waddr),
    .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd), .o_busy(busy),
    .o_swapped(swapped));

  i2cs_bus_master i_bus (.i_ref_clk(i_ref_clk), .i_sda(sda),
    .o_sda_low(m_sda_low), .o_scl_low(m_scl_low));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk)
  begin
    if (wr === 1'b1)
      regs[waddr] = wdata;
    if (rd === 1'b1)
      rd_cnt++;
    cyc++;
    // Whole run is about 75000 cycles at the chosen bus rates
    if (cyc == 95000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'hA5;
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic [7:0] b, input logic e);
    i_bus.xfer(b, 1'b1, rx, ak);
    chk("ack", 8'(ak), 8'(e));
  endtask

  task automatic rb(input logic a, input logic [7:0] e);
    i_bus.xfer(8'hFF, a, rx, ak);
    chk("rdata", rx, e);
  endtask

  task automatic wrap_up();
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("oe_n", {6'h00, d_oe_n, c_oe_n}, 8'h03);
    chk("pin_out", {6'h00, d_out, c_out}, 8'h00);
    chk("ptr", ptr, `I2CS_PTR_RESET);
    chk("busy", 8'(busy), 8'h00);
  endtask

  task automatic t_write();
    i_bus.start();
    chk("busy", 8'(busy), 8'h01);
    wb({`I2CS_ADDR_DIRECT, 1'b0}, 1'b0);
    wb(8'h05, 1'b0);
    wb(8'hC3, 1'b0);
    wb(8'h3C, 1'b0);
    i_bus.stop();
    wt(10);
    chk("busy", 8'(busy), 8'h00);
    chk("reg5", regs[5], 8'hC3);
    chk("reg6", regs[6], 8'h3C);
    chk("ptr", ptr, 8'h07);
  endtask

  // Read without a pointer write continues where the write left off
  task automatic t_read();
    rd_base = rd_cnt;
    i_bus.start();
    wb({`I2CS_ADDR_DIRECT, `I2CS_DIR_READ}, 1'b0);
    rb(1'b0, pat(8'h07));
    rb(1'b0, pat(8'h08));
    rb(1'b1, pat(8'h09));
    wt(20);
    chk("sda", 8'(sda), 8'h01);
    i_bus.stop();
    chk("ptr", ptr, 8'h0A);
    chk("rd_pulses", 8'(rd_cnt - rd_base), 8'h03);
  endtask

  task automatic t_rstart();
    i_bus.start();
    wb({`I2CS_ADDR_DIRECT, 1'b0}, 1'b0);
    wb(8'h20, 1'b0);
    i_bus.start();
    wb({`I2CS_ADDR_DIRECT, `I2CS_DIR_READ}, 1'b0);
    rb(1'b1, pat(8'h20));
    i_bus.stop();
  endtask

  // Other address: no acknowledge, following byte ignored
  task automatic t_nomatch();
    i_bus.start();
    wb({`I2CS_ADDR_SWAPPED, 1'b0}, 1'b1);
    wb(8'h40, 1'b1);
    i_bus.stop();
    chk("ptr", ptr, 8'h21);
  endtask

  // Identification register read twice over crossed wiring
  task automatic t_swap();
    swap = 1'b1;
    repeat (2)
    begin
      i_bus.start();
      wb({`I2CS_ADDR_SWAPPED, 1'b0}, 1'b0);
      wb(8'h00, 1'b0);
      i_bus.start();
      wb({`I2CS_ADDR_SWAPPED, `I2CS_DIR_READ}, 1'b0);
      rb(1'b1, pat(8'h00));
      i_bus.stop();
    end
    chk("swapped", 8'(swapped), 8'h01);
    wt(5);
    swap = 1'b0;
  endtask

  task automatic t_slow();
    i_bus.qtr = 250;
    i_bus.start();
    wb({`I2CS_ADDR_DIRECT, `I2CS_DIR_READ}, 1'b0);
    rb(1'b1, pat(8'h01));
    i_bus.stop();
    chk("swapped", 8'(swapped), 8'h00);
    i_bus.qtr = 63;
  endtask

  initial
  begin
    i_sys_rst = 1'b1;
    swap = 1'b0;
    for (int i = 0; i < 256; i++)
      regs[i] = pat(8'(i));
    repeat (5) @(posedge i_ref_clk);
    #1;
    i_sys_rst = 1'b0;
    wt(6);
    t_reset();
    t_write();
    t_read();
    t_rstart();
    t_nomatch();
    t_swap();
    t_slow();
    wrap_up();
  end
endmodule
